// File: bridge_defs.vh
// constants for the request decoder and option byte bank
`ifndef BRIDGE_DEFS_VH
`define BRIDGE_DEFS_VH
`define OPT_LO_ADDR 4'h2
`define OPT_HI_ADDR 4'h9
`define OPT_INIT_ADDR 4'h8
`define OPT_RPT_ADDR 4'h9
`define OPT_02_RST 8'h00
`define OPT_03_RST 8'h00
`define OPT_04_RST 8'h02
`define OPT_05_RST 8'h0b
`define OPT_06_RST 8'h00
`define OPT_07_RST 8'h00
`define OPT_08_RST 8'h30
`define OPT_09_RST 8'h00
`define B_INIT_ACTIVE 7
`define B_CFG2_PRESENT 6
`define B_SKIP_INIT 5
`define B_HIGH_POWER 4
`define B_DESC_OVERRIDE 3
`define F_UNIT_HI 2
`define F_UNIT_LO 0
`define B_REPORT_ONE 1
`define B_SOFT_RST_EN 0
`define RT_STD_OUT 8'h00
`define RT_STD_IN 8'h80
`define RT_STD_IF_OUT 8'h01
`define RT_STD_IF_IN 8'h81
`define RT_STD_EP_OUT 8'h02
`define RT_STD_EP_IN 8'h82
`define RT_CLASS_OUT 8'h21
`define RT_CLASS_IN 8'ha1
`define RT_VEND_OUT 8'h40
`define RT_VEND_IN 8'hc0
`define RQ_SET_DESCRIPTOR 8'h07
`define RQ_STD_MAX 8'h0b
`define RQ_FULL_RESET 8'hff
`define RQ_UNIT_COUNT 8'hfe
`define RQ_CFG_WRITE 8'h01
`define RQ_CFG_READ 8'h02
`define RQ_DATAPATH_RST 8'h03
`define RQ_QUEUE_MODE 8'h04
`define TGT_OPTIONS 16'h0000
`define TGT_INT_ROM 16'h0001
`define TGT_SER_ROM 16'h0002
`define TGT_IDENT 16'h0003
`define QUEUE_SIMPLE 16'h0000
`define QUEUE_COMPLEX 16'h0001
`define OVR_CLASS 8'hff
`define OVR_SUBCLASS 8'h00
`define OVR_PROTOCOL 8'hff
`define BULK_MAX_PACKET 7'h40
`define INTR_ANSWER 8'h00
`define CLK_PERIOD_NS 10
`define DRV_RST_NS 25000
`define DRV_RST_CYC ((`DRV_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: option_bank.v
// option byte bank at addresses 0x2 to 0x9
`timescale 1ns/1ps
`include "bridge_defs.vh"
module option_bank (
  input wire mclk,
  input wire clr,
  input wire ce,
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [3:0] rd_addr,
  input wire init_active,
  output wire [7:0] rd_data,
  output wire [7:0] init_byte,
  output wire [7:0] report_byte
);
  reg [7:0] mem [2:9];
  wire [7:0] raw;

  // bit 7 of option byte 0x8 mirrors hardware, never storage
  assign raw = (rd_addr >= `OPT_LO_ADDR && rd_addr <= `OPT_HI_ADDR) ?
               mem[rd_addr] : 8'h00;
  assign rd_data = (rd_addr == `OPT_INIT_ADDR) ?
                   {init_active, raw[6:0]} : raw; // see RULE_01
  assign init_byte = {init_active, mem[`OPT_INIT_ADDR][6:0]}; // see RULE_27
  assign report_byte = mem[`OPT_RPT_ADDR];

  always @(posedge mclk) begin
    if (clr) begin
      mem[2] <= `OPT_02_RST;
      mem[3] <= `OPT_03_RST;
      mem[4] <= `OPT_04_RST;
      mem[5] <= `OPT_05_RST;
      mem[6] <= `OPT_06_RST;
      mem[7] <= `OPT_07_RST;
      mem[8] <= `OPT_08_RST;
      mem[9] <= `OPT_09_RST;
    end else if (ce && wr_en && wr_addr >= `OPT_LO_ADDR &&
                 wr_addr <= `OPT_HI_ADDR) begin
      // only the internal copy changes; sources stay as they are
      mem[wr_addr] <= wr_data; // see RULE_22
    end
  end
endmodule

// File: power_policy.v
// combinational descriptor, power and configuration policy
`timescale 1ns/1ps
`include "bridge_defs.vh"
module power_policy (
  input wire [7:0] init_byte,
  input wire [7:0] report_byte,
  input wire inbound_cfg_pin,
  input wire bus_powered,
  input wire [7:0] usb_config,
  input wire drive_is_ata,
  input wire init_failed,
  output wire skip_init,
  output wire low_power,
  output wire desc_override,
  output wire offer_cfg1,
  output wire offer_cfg2,
  output wire soft_reset_algorithm
);
  wire cfg2 = init_byte[`B_CFG2_PRESENT];
  wire rpt1 = report_byte[`B_REPORT_ONE];

  assign skip_init = init_byte[`B_SKIP_INIT] & ~inbound_cfg_pin; // see RULE_03
  assign low_power = init_byte[`B_HIGH_POWER] & bus_powered &
                     (usb_config == 8'h00); // see RULE_04
  assign desc_override = init_byte[`B_DESC_OVERRIDE] & ~inbound_cfg_pin &
                         (drive_is_ata | init_failed); // see RULE_05
  // without a second descriptor only configuration 1 exists
  assign offer_cfg1 = ~cfg2 | ~rpt1 | bus_powered; // see RULE_07
  assign offer_cfg2 = cfg2 & (rpt1 ? ~bus_powered : ~bus_powered);
  assign soft_reset_algorithm = report_byte[`B_SOFT_RST_EN]; // see RULE_08
endmodule

// File: request_decoder.v
// control request decoder with option bytes and drive power control
// Functional notes
// RULE_01 - init status bit reads one while initializing
// RULE_02 - bit six flags second configuration present
// RULE_03 - skip init only resets; pin forces zero
// RULE_04 - high power, bus powered, unconfigured: drive pads off
// RULE_05 - override reports vendor class, odd product id
// RULE_06 - three-bit highest logical unit field
// RULE_07 - report-one bit picks offered configurations
// RULE_08 - soft reset algorithm enabled by bit zero
// RULE_09 - host uses only valid pin/option combinations
// RULE_10 - stored descriptors use fixed string indexes
// RULE_11 - bulk pipes carry traffic, 64-byte packets
// RULE_12 - interrupt pipe always answers zero
// RULE_13 - all standard requests except set descriptor; the code also stalls codes 0x02 and 0x04
// RULE_14 - full reset decoded by exact encoding
// RULE_15 - full reset restores defaults, pulses drive reset
// RULE_16 - full reset keeps stalls and data toggles
// RULE_17 - unit count returns highest unit byte
// RULE_18 - vendor request types and codes
// RULE_19 - config write: value target, index, length
// RULE_20 - serial rom writes aligned, within one page
// RULE_21 - option writes outside 0x2-0x9 stall
// RULE_22 - option writes never touch original source
// RULE_23 - config read targets 0-3, others stall
// RULE_24 - datapath reset spares the drive
// RULE_25 - queue mode simple or complex by index
// RULE_26 - unknown requests stall
// RULE_27 - writes to init status bit ignored
`timescale 1ns/1ps
`include "bridge_defs.vh"
module request_decoder #(
  parameter RST_CYC = `DRV_RST_CYC
) (
  input wire mclk,
  input wire sys_rst,
  input wire ce,
  input wire setup_valid,
  input wire [7:0] req_type,
  input wire [7:0] req_code,
  input wire [15:0] req_value,
  input wire [15:0] req_index,
  input wire [15:0] req_length,
  input wire out_valid,
  input wire [7:0] out_byte,
  input wire in_ready,
  input wire intr_poll,
  input wire inbound_cfg_pin,
  input wire bus_powered,
  input wire [7:0] usb_config,
  input wire drive_is_ata,
  input wire init_failed,
  input wire init_active,
  input wire rom_present,
  output reg ctl_stall,
  output reg ctl_done,
  output reg std_req,
  output reg in_valid,
  output reg [7:0] in_byte,
  output reg ext_req,
  output reg ext_write,
  output reg [1:0] ext_target,
  output reg [15:0] ext_addr,
  output reg [15:0] ext_length,
  output reg intr_valid,
  output reg [7:0] intr_byte,
  output reg [6:0] bulk_max_packet,
  output reg datapath_reset,
  output reg chip_reset,
  output reg queue_complex,
  output reg drive_hw_reset_pin_n,
  output reg drive_reset_oe_n,
  output reg strobes_oe_n,
  output reg bus_force_low,
  output reg ready_pullup_enable,
  output reg pad_low_power,
  output reg skip_init,
  output reg desc_override,
  output reg [7:0] ovr_class,
  output reg [7:0] ovr_subclass,
  output reg [7:0] ovr_protocol,
  output reg pid_bit0_force,
  output reg cfg2_present,
  output reg offer_cfg1,
  output reg offer_cfg2,
  output reg soft_reset_algorithm,
  output reg [2:0] highest_unit_field
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_WR = 4'b0010;
  localparam ST_RD = 4'b0100;
  localparam ST_ONE = 4'b1000;

  reg [3:0] state;
  reg [3:0] addr;
  reg [15:0] left;
  reg [12:0] rst_cnt;
  reg full_clr;
  reg [7:0] wr_data;
  reg bank_wr;
  reg [3:0] bank_wr_addr;

  wire [7:0] rd_data;
  wire [7:0] init_byte;
  wire [7:0] report_byte;
  wire p_skip;
  wire p_low;
  wire p_ovr;
  wire p_cfg1;
  wire p_cfg2;
  wire p_soft_reset_algorithm;

  // true when [start, start+len-1] lies inside option bytes 0x2..0x9
  function opt_span_ok;
    input [15:0] start;
    input [15:0] len;
    reg [16:0] last;
    begin
      last = {1'b0, start} + {1'b0, len} - 17'd1;
      opt_span_ok = (start >= {12'h000, `OPT_LO_ADDR}) &&
                    (len == 16'h0000 ||
                     last <= {13'h0000, `OPT_HI_ADDR});
    end
  endfunction

  // zero value and zero length, as the no-data requests require
  function no_data;
    input [15:0] val;
    input [15:0] len;
    begin
      no_data = (val == 16'h0000) && (len == 16'h0000);
    end
  endfunction

  option_bank u_bank (
    .mclk(mclk),
    .clr(sys_rst | full_clr),
    .ce(ce),
    .wr_en(bank_wr),
    .wr_addr(bank_wr_addr),
    .wr_data(wr_data),
    .rd_addr(addr),
    .init_active(init_active),
    .rd_data(rd_data),
    .init_byte(init_byte),
    .report_byte(report_byte)
  );

  power_policy u_policy (
    .init_byte(init_byte),
    .report_byte(report_byte),
    .inbound_cfg_pin(inbound_cfg_pin),
    .bus_powered(bus_powered),
    .usb_config(usb_config),
    .drive_is_ata(drive_is_ata),
    .init_failed(init_failed),
    .skip_init(p_skip),
    .low_power(p_low),
    .desc_override(p_ovr),
    .offer_cfg1(p_cfg1),
    .offer_cfg2(p_cfg2),
    .soft_reset_algorithm(p_soft_reset_algorithm)
  );

  wire std_type = (req_type == `RT_STD_OUT) || (req_type == `RT_STD_IN) ||
                  (req_type == `RT_STD_IF_OUT) ||
                  (req_type == `RT_STD_IF_IN) ||
                  (req_type == `RT_STD_EP_OUT) ||
                  (req_type == `RT_STD_EP_IN);
  wire is_full_rst = req_type == `RT_CLASS_OUT &&
                     req_code == `RQ_FULL_RESET &&
                     no_data(req_value, req_length); // see RULE_14
  wire is_unit_cnt = req_type == `RT_CLASS_IN &&
                     req_code == `RQ_UNIT_COUNT &&
                     req_value == 16'h0000 &&
                     req_length == 16'h0001; // see RULE_17
  wire is_cfg_wr = req_type == `RT_VEND_OUT &&
                   req_code == `RQ_CFG_WRITE; // see RULE_18
  wire is_cfg_rd = req_type == `RT_VEND_IN && req_code == `RQ_CFG_READ;
  wire is_dp_rst = req_type == `RT_VEND_OUT &&
                   req_code == `RQ_DATAPATH_RST &&
                   no_data(req_value, req_length) &&
                   req_index == 16'h0000;
  wire is_queue = req_type == `RT_VEND_OUT &&
                  req_code == `RQ_QUEUE_MODE &&
                  no_data(req_value, req_length) &&
                  (req_index == `QUEUE_SIMPLE ||
                   req_index == `QUEUE_COMPLEX);
  wire is_std = std_type && req_code <= `RQ_STD_MAX &&
                req_code != `RQ_SET_DESCRIPTOR &&
                req_code != 8'h02 && req_code != 8'h04; // see RULE_13

  always @(posedge mclk) begin
    if (sys_rst || full_clr) begin
      state <= ST_IDLE;
      addr <= 4'h0;
      left <= 16'h0000;
      bank_wr <= 1'b0;
      bank_wr_addr <= 4'h0;
      wr_data <= 8'h00;
      ctl_stall <= 1'b0;
      ctl_done <= 1'b0;
      std_req <= 1'b0;
      in_valid <= 1'b0;
      in_byte <= 8'h00;
      ext_req <= 1'b0;
      ext_write <= 1'b0;
      ext_target <= 2'b00;
      ext_addr <= 16'h0000;
      ext_length <= 16'h0000;
      intr_valid <= 1'b0;
      intr_byte <= `INTR_ANSWER;
      datapath_reset <= 1'b0;
      queue_complex <= 1'b0; // see RULE_25
      full_clr <= 1'b0;
    end else if (ce) begin
      ctl_stall <= 1'b0;
      ctl_done <= 1'b0;
      std_req <= 1'b0;
      ext_req <= 1'b0;
      datapath_reset <= 1'b0;
      bank_wr <= 1'b0;
      intr_valid <= intr_poll;
      intr_byte <= `INTR_ANSWER; // see RULE_12
      case (state)
        ST_IDLE: begin
          if (setup_valid) begin
            addr <= req_index[3:0];
            left <= req_length;
            if (is_std) begin
              std_req <= 1'b1;
            end else if (is_full_rst) begin
              // drive reset and chip defaults; stalls/toggles live outside
              full_clr <= 1'b1; // see RULE_15, RULE_16
              ctl_done <= 1'b1;
            end else if (is_unit_cnt) begin
              in_byte <= {5'h00, init_byte[`F_UNIT_HI:`F_UNIT_LO]};
              in_valid <= 1'b1;
              state <= ST_ONE; // see RULE_17
            end else if (is_cfg_wr && req_value == `TGT_OPTIONS) begin
              if (opt_span_ok(req_index, req_length)) begin
                state <= (req_length == 16'h0000) ? ST_IDLE : ST_WR;
                ctl_done <= (req_length == 16'h0000);
              end else begin
                ctl_stall <= 1'b1; // see RULE_21
              end
            end else if (is_cfg_wr && req_value == `TGT_SER_ROM &&
                         rom_present) begin
              ext_req <= 1'b1; // see RULE_19
              ext_write <= 1'b1;
              ext_target <= req_value[1:0];
              ext_addr <= req_index;
              ext_length <= req_length;
            end else if (is_cfg_rd && req_value == `TGT_OPTIONS) begin
              if (opt_span_ok(req_index, req_length) &&
                  req_length != 16'h0000) begin
                state <= ST_RD;
              end else if (req_length == 16'h0000 &&
                           req_index[15:4] == 12'h000) begin
                ctl_done <= 1'b1;
              end else begin
                ctl_stall <= 1'b1;
              end
            end else if (is_cfg_rd &&
                         (req_value == `TGT_INT_ROM ||
                          (req_value == `TGT_SER_ROM && rom_present) ||
                          (req_value == `TGT_IDENT && inbound_cfg_pin &&
                           !rom_present))) begin
              ext_req <= 1'b1; // see RULE_23
              ext_write <= 1'b0;
              ext_target <= req_value[1:0];
              ext_addr <= req_index;
              ext_length <= req_length;
            end else if (is_dp_rst) begin
              datapath_reset <= 1'b1; // see RULE_24
              ctl_done <= 1'b1;
            end else if (is_queue) begin
              queue_complex <= req_index[0]; // see RULE_25
              ctl_done <= 1'b1;
            end else begin
              ctl_stall <= 1'b1; // see RULE_26
            end
          end
        end
        ST_WR: begin
          if (out_valid) begin
            bank_wr <= 1'b1;
            bank_wr_addr <= addr;
            wr_data <= out_byte; // status bit is masked in the bank
            addr <= addr + 4'h1;
            left <= left - 16'h0001;
            if (left == 16'h0001) begin
              state <= ST_IDLE;
              ctl_done <= 1'b1;
            end
          end
        end
        ST_RD: begin
          if (!in_valid) begin
            in_byte <= rd_data;
            in_valid <= 1'b1;
          end else if (in_ready) begin
            in_valid <= 1'b0;
            addr <= addr + 4'h1;
            left <= left - 16'h0001;
            if (left == 16'h0001) begin
              state <= ST_IDLE;
              ctl_done <= 1'b1;
            end
          end
        end
        ST_ONE: begin
          if (in_ready) begin
            in_valid <= 1'b0;
            state <= ST_IDLE;
            ctl_done <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // drive reset pulse; the counter survives the full reset it serves
  always @(posedge mclk) begin
    if (sys_rst) begin
      rst_cnt <= 13'h0000;
      chip_reset <= 1'b0;
    end else if (ce) begin
      chip_reset <= full_clr;
      if (full_clr) begin
        rst_cnt <= RST_CYC[12:0]; // see RULE_15
      end else if (rst_cnt != 13'h0000) begin
        rst_cnt <= rst_cnt - 13'h0001;
      end
    end
  end

  // registered policy outputs and pad control
  always @(posedge mclk) begin
    if (sys_rst) begin
      drive_hw_reset_pin_n <= 1'b1;
      drive_reset_oe_n <= 1'b0;
      strobes_oe_n <= 1'b0;
      bus_force_low <= 1'b0;
      ready_pullup_enable <= 1'b1;
      pad_low_power <= 1'b0;
      skip_init <= 1'b0;
      desc_override <= 1'b0;
      ovr_class <= 8'h00;
      ovr_subclass <= 8'h00;
      ovr_protocol <= 8'h00;
      pid_bit0_force <= 1'b0;
      cfg2_present <= 1'b0;
      offer_cfg1 <= 1'b1;
      offer_cfg2 <= 1'b0;
      soft_reset_algorithm <= 1'b0;
      highest_unit_field <= 3'h0;
      bulk_max_packet <= `BULK_MAX_PACKET;
    end else if (ce) begin
      drive_hw_reset_pin_n <= (rst_cnt == 13'h0000) && !full_clr;
      // reset line and strobes float; the rest are held low
      drive_reset_oe_n <= p_low; // see RULE_04
      strobes_oe_n <= p_low;
      bus_force_low <= p_low;
      ready_pullup_enable <= !p_low;
      pad_low_power <= p_low;
      skip_init <= p_skip; // see RULE_03
      desc_override <= p_ovr;
      ovr_class <= `OVR_CLASS; // see RULE_05
      ovr_subclass <= `OVR_SUBCLASS;
      ovr_protocol <= `OVR_PROTOCOL;
      pid_bit0_force <= p_ovr;
      cfg2_present <= init_byte[`B_CFG2_PRESENT]; // see RULE_02
      offer_cfg1 <= p_cfg1; // see RULE_07
      offer_cfg2 <= p_cfg2;
      soft_reset_algorithm <= p_soft_reset_algorithm; // see RULE_08
      highest_unit_field <= init_byte[`F_UNIT_HI:`F_UNIT_LO]; // see RULE_06
      bulk_max_packet <= `BULK_MAX_PACKET; // see RULE_11
    end
  end
endmodule

// File: usb_host_model.sv
// host side model: control setups and data stage bytes
`timescale 1ns/1ps
module usb_host_model (
  input wire mclk,
  input wire in_valid,
  input wire [7:0] in_byte,
  output reg setup_valid,
  output reg [7:0] req_type,
  output reg [7:0] req_code,
  output reg [15:0] req_value,
  output reg [15:0] req_index,
  output reg [15:0] req_length,
  output reg out_valid,
  output reg [7:0] out_byte,
  output reg in_ready
);
  initial begin
    {setup_valid, out_valid, in_ready} = 3'h0;
    {req_type, req_code, req_value, req_index, req_length, out_byte} = 72'h0;
  end
  // encodings go out exactly as given; fields are scrambled once released
  task send(input [63:0] f);
    @(negedge mclk);
    setup_valid = 1'b1;
    {req_type, req_code, req_value, req_index, req_length} = f;
    @(negedge mclk);
    setup_valid = 1'b0;
    {req_type, req_code, req_value, req_index, req_length} = ~f;
  endtask
  task give(input [7:0] b);
    @(negedge mclk);
    out_valid = 1'b1;
    out_byte = b;
    @(negedge mclk);
    out_valid = 1'b0;
    out_byte = ~b;
  endtask
  // gives up after ten cycles and hands back an unknown byte
  task take(output [7:0] d);
    integer n;
    d = 8'hxx;
    for (n = 0; n < 10 && !in_valid; n = n + 1)
      @(negedge mclk);
    if (in_valid) begin
      in_ready = 1'b1;
      d = in_byte;
      @(negedge mclk);
      in_ready = 1'b0;
    end
  endtask
endmodule

// File: decoder_chk.sv
// port assertions for the request decoder
`timescale 1ns/1ps
module decoder_chk #(
  parameter RST_CYC = 4
) (
  input wire mclk,
  input wire sys_rst,
  input wire ce,
  input wire setup_valid,
  input wire [7:0] req_type,
  input wire [7:0] req_code,
  input wire [15:0] req_value,
  input wire [15:0] req_length,
  input wire intr_poll,
  input wire inbound_cfg_pin,
  input wire bus_powered,
  input wire [7:0] usb_config,
  input wire drive_is_ata,
  input wire init_failed,
  input wire ctl_stall,
  input wire in_valid,
  input wire [7:0] in_byte,
  input wire intr_valid,
  input wire [7:0] intr_byte,
  input wire [6:0] bulk_max_packet,
  input wire chip_reset,
  input wire drive_hw_reset_pin_n,
  input wire drive_reset_oe_n,
  input wire strobes_oe_n,
  input wire bus_force_low,
  input wire ready_pullup_enable,
  input wire pad_low_power,
  input wire skip_init,
  input wire desc_override,
  input wire [7:0] ovr_class,
  input wire pid_bit0_force,
  input wire offer_cfg2,
  input wire [2:0] highest_unit_field
);
  integer low_cnt;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // counts how long the drive has been held in reset
  always @(posedge mclk) begin
    if (sys_rst || drive_hw_reset_pin_n)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;
  end
  sequence req_seen(t, c);
    ce && setup_valid && req_type == t && req_code == c;
  endsequence
  sequence drive_pulse;
    ##[1:2] chip_reset ##[0:3] !drive_hw_reset_pin_n;
  endsequence
  property full_reset_p;
    req_seen(8'h21, 8'hff) ##0 (req_value == 16'h0 && req_length == 16'h0)
      |-> drive_pulse;
  endproperty
  full_reset_a: assert property (full_reset_p)
    else $error("full reset gave no drive reset");
  reset_width_a: assert property (
    $rose(drive_hw_reset_pin_n) |-> low_cnt >= RST_CYC)
    else $error("drive reset too short");
  intr_zero_a: assert property (
    ce && intr_poll |=> intr_valid && intr_byte == 8'h00)
    else $error("interrupt answer wrong");
  bulk_size_a: assert property (bulk_max_packet == 7'h40)
    else $error("bulk packet size wrong");
  unit_count_a: assert property (
    req_seen(8'ha1, 8'hfe) ##0 req_length == 16'h1
      |=> in_valid && in_byte == {5'h00, highest_unit_field})
    else $error("unit count answer wrong");
  set_desc_a: assert property (req_seen(8'h00, 8'h07) |=> ctl_stall)
    else $error("set descriptor not stalled");
  low_power_a: assert property (
    pad_low_power |-> $past(bus_powered) && $past(usb_config) == 8'h00 &&
      bus_force_low && drive_reset_oe_n && strobes_oe_n && !ready_pullup_enable)
    else $error("low power pad state wrong");
  skip_pin_a: assert property (skip_init |-> !$past(inbound_cfg_pin))
    else $error("skip set with pin high");
  override_a: assert property (
    desc_override |-> !$past(inbound_cfg_pin) && pid_bit0_force &&
      ($past(drive_is_ata) || $past(init_failed)) && ovr_class == 8'hff)
    else $error("override without cause");
  offer_a: assert property (offer_cfg2 |-> !$past(bus_powered))
    else $error("second config offered on bus power");
endmodule
bind request_decoder decoder_chk #(.RST_CYC(RST_CYC)) decoder_chk_i (.*);

// File: usb_bridge_request_and_config_bank_test.sv
// self-checking bench for the control request decoder
`timescale 1ns/1ps
module usb_bridge_request_and_config_bank_test;
  reg mclk, sys_rst, ce, intr_poll, inbound_cfg_pin, bus_powered;
  reg drive_is_ata, init_failed, init_active, rom_present;
  reg [7:0] usb_config;
  wire setup_valid, out_valid, in_ready, ctl_stall, ctl_done, std_req;
  wire [7:0] req_type, req_code, out_byte, in_byte, intr_byte;
  wire [15:0] req_value, req_index, req_length, ext_addr, ext_length;
  wire in_valid, ext_req, ext_write, intr_valid, datapath_reset;
  wire chip_reset, queue_complex, drive_hw_reset_pin_n, drive_reset_oe_n;
  wire strobes_oe_n, bus_force_low, ready_pullup_enable, pad_low_power;
  wire skip_init, desc_override, pid_bit0_force, cfg2_present;
  wire offer_cfg1, offer_cfg2, soft_reset_algorithm;
  wire [7:0] ovr_class, ovr_subclass, ovr_protocol;
  wire [1:0] ext_target;
  wire [6:0] bulk_max_packet;
  wire [2:0] highest_unit_field;
  wire [4:0] pads = {pad_low_power, bus_force_low, drive_reset_oe_n,
    strobes_oe_n, ready_pullup_enable};
  reg [68:0] rows [0:11];
  reg [4:0] res;
  reg [15:0] ea, el;
  reg [7:0] d;
  integer checks, n_fail, k, n;
  request_decoder #(.RST_CYC(4)) request_decoder_i (.*);
  usb_host_model usb_host_model_i (.*);
  task chk(input [8*10-1:0] what, input [15:0] seen, input [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %0s exp %h seen %h", what, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task tick(input integer c);
    repeat (c) @(negedge mclk);
  endtask
  // one extra cycle is merged in, since side pulses may trail the answer
  task finish_req;
    res = 5'h00;
    for (n = 0; n < 40 && res == 5'h00; n = n + 1) begin
      // the one-cycle answer may already stand when the request returns
      res = {datapath_reset, ext_req, std_req, ctl_stall, ctl_done};
      if (res == 5'h00)
        @(negedge mclk);
    end
    ea = ext_addr;
    el = ext_length;
    @(negedge mclk);
    res = res | {datapath_reset, ext_req, std_req, ctl_stall, ctl_done};
    if (res == 5'h00) begin
      n_fail = n_fail + 1;
      test_done;
    end
  endtask
  task opt_write(input [15:0] idx, input [7:0] b);
    usb_host_model_i.send({8'h40, 8'h01, 16'h0, idx, 16'h1});
    usb_host_model_i.give(b);
    finish_req;
    tick(1);
    chk("write", res, 5'h01);
  endtask
  task opt_read(input [15:0] idx);
    usb_host_model_i.send({8'hc0, 8'h02, 16'h0, idx, 16'h1});
    usb_host_model_i.take(d);
    finish_req;
    chk("read", res, 5'h01);
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    // type, code, value, index, length, {dp, ext, std, stall, done}
    rows[0] = {8'h00, 8'h00, 16'h0, 16'h0, 16'h0, 5'h04};
    rows[1] = {8'h00, 8'h07, 16'h0, 16'h0, 16'h0, 5'h02};
    rows[2] = {8'h00, 8'h02, 16'h0, 16'h0, 16'h0, 5'h02};
    rows[3] = {8'h21, 8'hff, 16'h1, 16'h0, 16'h0, 5'h02};
    rows[4] = {8'h40, 8'h03, 16'h0, 16'h0, 16'h0, 5'h11};
    rows[5] = {8'h40, 8'h01, 16'h2, 16'h8, 16'h8, 5'h08};
    rows[6] = {8'h40, 8'h01, 16'h1, 16'h2, 16'h1, 5'h02};
    rows[7] = {8'h40, 8'h01, 16'h0, 16'h9, 16'h2, 5'h02};
    rows[8] = {8'hc0, 8'h02, 16'h1, 16'h0, 16'h4, 5'h08};
    rows[9] = {8'hc0, 8'h02, 16'h4, 16'h0, 16'h1, 5'h02};
    rows[10] = {8'h40, 8'h04, 16'h0, 16'h1, 16'h0, 5'h01};
    rows[11] = {8'hc0, 8'h02, 16'h3, 16'h0, 16'h1, 5'h02};
    {sys_rst, ce, rom_present, drive_is_ata} = 4'hf;
    {intr_poll, inbound_cfg_pin, bus_powered, init_failed, init_active} = 5'h0;
    usb_config = 8'h00;
    checks = 0;
    n_fail = 0;
    tick(5);
    sys_rst = 1'b0;
    for (k = 0; k < 12; k = k + 1) begin
      usb_host_model_i.send(rows[k][68:5]);
      finish_req;
      chk("outcome", res, rows[k][4:0]);
      if (rows[k][4:0] == 5'h08) begin
        chk("ext_addr", ea, rows[k][36:21]);
        chk("ext_len", el, rows[k][20:5]);
        chk("ext_tgt", {ext_write, ext_target},
          {~rows[k][68], rows[k][38:37]});
      end
    end
    rom_present = 1'b0;
    usb_host_model_i.send({8'h40, 8'h01, 16'h2, 16'h8, 16'h8});
    finish_req;
    chk("no rom", res, 5'h02);
    rom_present = 1'b1;
    $display("request table done");
    opt_read(16'h8);
    chk("byte8", d, 8'h30);
    opt_read(16'h9);
    chk("byte9", d, 8'h00);
    init_active = 1'b1;
    opt_read(16'h8);
    chk("busy bit", d, 8'hb0);
    init_active = 1'b0;
    opt_write(16'h8, 8'hff);
    opt_read(16'h8);
    chk("ro bit", d, 8'h7f);
    chk("units", highest_unit_field, 3'h7);
    chk("cfg2", cfg2_present, 1'b1);
    chk("override", {desc_override, pid_bit0_force}, 2'h3);
    chk("class", {ovr_class, ovr_protocol}, 16'hffff);
    chk("subclass", ovr_subclass, 8'h00);
    drive_is_ata = 1'b0;
    tick(2);
    chk("ovr none", desc_override, 1'b0);
    init_failed = 1'b1;
    tick(2);
    chk("ovr fail", desc_override, 1'b1);
    {drive_is_ata, init_failed} = 2'h2;
    usb_host_model_i.send({8'ha1, 8'hfe, 16'h0, 16'h0, 16'h1});
    usb_host_model_i.take(d);
    finish_req;
    chk("unit count", d, 8'h07);
    bus_powered = 1'b1;
    tick(2);
    chk("pads off", pads, 5'h1e);
    usb_config = 8'h01;
    tick(2);
    chk("pads on", pads, 5'h01);
    bus_powered = 1'b0;
    opt_write(16'h9, 8'h03);
    chk("soft rst", soft_reset_algorithm, 1'b1);
    chk("offer bp0", {offer_cfg1, offer_cfg2}, 2'h1);
    bus_powered = 1'b1;
    tick(2);
    chk("offer bp1", {offer_cfg1, offer_cfg2}, 2'h2);
    bus_powered = 1'b0;
    $display("option tests done");
    // pin high is only legal with override and high power both clear
    opt_write(16'h8, 8'h67);
    inbound_cfg_pin = 1'b1;
    tick(2);
    chk("skip pin", skip_init, 1'b0);
    inbound_cfg_pin = 1'b0;
    tick(2);
    chk("skip", skip_init, 1'b1);
    intr_poll = 1'b1;
    tick(1);
    intr_poll = 1'b0;
    chk("intr", {intr_valid, intr_byte}, 9'h100);
    chk("bulk size", bulk_max_packet, 7'h40);
    // with the enable low the last interrupt answer must stay frozen
    ce = 1'b0;
    tick(2);
    chk("ce hold", intr_valid, 1'b1);
    ce = 1'b1;
    $display("pin and pipe tests done");
    chk("queue", queue_complex, 1'b1);
    usb_host_model_i.send({8'h21, 8'hff, 16'h0, 16'h0, 16'h0});
    finish_req;
    chk("full reset", res, 5'h01);
    for (n = 0; n < 10 && drive_hw_reset_pin_n; n = n + 1)
      @(negedge mclk);
    for (k = 0; k < 40 && !drive_hw_reset_pin_n; k = k + 1)
      @(negedge mclk);
    chk("drive rst", k >= 4 && k < 40, 1'b1);
    chk("queue rst", queue_complex, 1'b0);
    opt_read(16'h9);
    chk("byte9 rst", d, 8'h00);
    $display("full reset test done");
    test_done;
  end
endmodule
